// file: sixteen_bit_timer_pkg.sv
// Purpose: constants and carrier types of the 16-bit timer/counter
// Assumes: APB slave, 32-bit data, one aligned word per register
// Notes:   count byte and control registers hold 8 bits in the low lane
package sixteen_bit_timer_pkg;
	localparam logic [7:0] ADDR_CTRL     = 8'h00;
	localparam logic [7:0] ADDR_CNT_LO   = 8'h04;
	localparam logic [7:0] ADDR_CNT_HI   = 8'h08;
	localparam logic [7:0] ADDR_CMP_VAL  = 8'h0C;
	localparam logic [7:0] ADDR_CMP_MODE = 8'h10;
	localparam logic [7:0] ADDR_STATUS   = 8'h14;
	localparam logic [7:0] ADDR_MASK     = 8'h18;
	localparam logic [7:0] ADDR_PORT_DIR = 8'h1C;

	localparam logic [3:0]  CMP_MODE_TRIGGER = 4'hB;
	localparam logic [15:0] COUNT_MAX        = 16'hFFFF;
	localparam logic [1:0]  PORT_DIR_RESET   = 2'h3;
	localparam int          STATUS_OVF_BIT   = 0;
	localparam int          INSTR_DIV        = 4;

	// control register layout, bit 7 down to bit 0
	typedef struct packed {
		logic       wide_access_mode;
		logic       unused6;
		logic [1:0] input_prescale_sel;
		logic       low_power_osc_enable;
		logic       ext_clock_sync_sel;
		logic       count_clock_source_sel;
		logic       counter_on;
	} ctrl_t;

	localparam ctrl_t CTRL_RESET = 8'h00;
endpackage : sixteen_bit_timer_pkg

// file: sixteen_bit_counter.sv
// Purpose: 16-bit up counter with prescaler, compare trigger and wide access
// Assumes: clk_i at 250 MHz; instruction cycle is a divided enable pulse
// Notes:   pins are synchronised by two flops before any logic reads them
//
// The register offsets and the APB slave port were decided locally.
`timescale 1ns/10ps
module sixteen_bit_counter #(
	parameter int INSTR_DIV = sixteen_bit_timer_pkg::INSTR_DIV
) (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        psel_i,
	input  wire logic        penable_i,
	input  wire logic        pwrite_i,
	input  wire logic [7:0]  paddr_i,
	input  wire logic [31:0] pwdata_i,
	output logic [31:0]      prdata_o,
	output logic             pready_o,
	output logic             pslverr_o,
	input  wire logic        ext_count_clock_pin_i,
	input  wire logic        osc_input_pin_i,
	input  wire logic        sleep_i,
	input  wire logic        adc_enable_i,
	output logic [1:0]       port_c_oe_o,
	output logic             conversion_start_o,
	output logic             irq_o
);
	sixteen_bit_timer_pkg::ctrl_t ctrl_q;
	logic [15:0] count_q;
	logic [15:0] count_d;
	logic [7:0]  buf_q;
	logic [15:0] cmp_q;
	logic [3:0]  cmp_mode_q;
	logic [1:0]  port_c_direction_q;
	logic        status_q;
	logic        mask_q;
	logic [2:0]  pre_q;
	logic [1:0]  div_q;
	logic        match_prev_q;
	logic [1:0]  sync1_q;
	logic [1:0]  sync2_q;
	logic        sel_prev_q;
	logic [31:0] prdata_q;
	logic        pready_q;
	logic        pslverr_q;
	logic        irq_q;
	logic        conv_q;
	logic [1:0]  port_oe_q;

	// bus phase decode
	wire setup_w  = psel_i & ~penable_i;
	wire access_w = psel_i & penable_i & pready_q;
	wire wr_w     = access_w & pwrite_i;
	wire wr_ctrl  = wr_w & (paddr_i == sixteen_bit_timer_pkg::ADDR_CTRL);
	wire wr_lo    = wr_w & (paddr_i == sixteen_bit_timer_pkg::ADDR_CNT_LO);
	wire wr_hi    = wr_w & (paddr_i == sixteen_bit_timer_pkg::ADDR_CNT_HI);
	wire wr_cmp   = wr_w & (paddr_i == sixteen_bit_timer_pkg::ADDR_CMP_VAL);
	wire wr_mode  = wr_w & (paddr_i == sixteen_bit_timer_pkg::ADDR_CMP_MODE);
	wire wr_stat  = wr_w & (paddr_i == sixteen_bit_timer_pkg::ADDR_STATUS);
	wire wr_mask  = wr_w & (paddr_i == sixteen_bit_timer_pkg::ADDR_MASK);
	wire wr_dir   = wr_w & (paddr_i == sixteen_bit_timer_pkg::ADDR_PORT_DIR);
	wire rd_lo    = setup_w & ~pwrite_i & (paddr_i == sixteen_bit_timer_pkg::ADDR_CNT_LO);
	wire wide     = ctrl_q.wide_access_mode;
	wire mapped_w = (paddr_i[7:5] == 3'h0) & (paddr_i[1:0] == 2'h0);

	// read mux; the high address shows the buffer in wide mode
	logic [7:0] rd_byte;
	always_comb begin
		rd_byte = 8'h00;
		case (paddr_i)
			sixteen_bit_timer_pkg::ADDR_CTRL:     rd_byte = ctrl_q & 8'hBF;
			sixteen_bit_timer_pkg::ADDR_CNT_LO:   rd_byte = count_q[7:0];
			sixteen_bit_timer_pkg::ADDR_CNT_HI:   rd_byte = wide ? buf_q : count_q[15:8];
			sixteen_bit_timer_pkg::ADDR_CMP_MODE: rd_byte = {4'h0, cmp_mode_q};
			sixteen_bit_timer_pkg::ADDR_STATUS:   rd_byte = {7'h00, status_q};
			sixteen_bit_timer_pkg::ADDR_MASK:     rd_byte = {7'h00, mask_q};
			sixteen_bit_timer_pkg::ADDR_PORT_DIR: rd_byte = {6'h00, port_c_direction_q};
			default:                              rd_byte = 8'h00;
		endcase
	end
	wire [31:0] rd_word = (paddr_i == sixteen_bit_timer_pkg::ADDR_CMP_VAL) ?
		{16'h0000, cmp_q} : {24'h000000, rd_byte};

	// instruction cycle enable from the clock divider
	wire instr_tick = (div_q == 2'(INSTR_DIV - 1));
	always_ff @(posedge clk_i) begin
		if (rst_i) div_q <= 2'h0;
		else       div_q <= instr_tick ? 2'h0 : div_q + 2'h1;
	end

	// two-flop synchronisers for both pins
	wire [1:0] pins_w = {osc_input_pin_i, ext_count_clock_pin_i};
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_sync
			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					sync1_q[gi] <= 1'b0;
					sync2_q[gi] <= 1'b0;
				end else begin
					sync1_q[gi] <= pins_w[gi];
					sync2_q[gi] <= sync1_q[gi];
				end
			end
		end
	endgenerate

	// count clock selection and prescaler
	wire sel_pin  = ctrl_q.low_power_osc_enable ? sync2_q[1] : sync2_q[0];
	wire ext_rise = sel_pin & ~sel_prev_q;
	wire asyn     = ctrl_q.ext_clock_sync_sel;
	wire ext_tick = ext_rise & (asyn | ~sleep_i);
	wire src_tick = ctrl_q.count_clock_source_sel ? ext_tick : (instr_tick & ~sleep_i);
	wire cnt_tick = ctrl_q.counter_on & src_tick;
	logic [2:0] pre_mask;
	always_comb begin
		case (ctrl_q.input_prescale_sel)
			2'h0:    pre_mask = 3'h0;
			2'h1:    pre_mask = 3'h1;
			2'h2:    pre_mask = 3'h3;
			default: pre_mask = 3'h7;
		endcase
	end
	wire inc_w = cnt_tick & ((pre_q & pre_mask) == pre_mask);

	// compare trigger on the first cycle of a match
	wire match_w = (cmp_mode_q == sixteen_bit_timer_pkg::CMP_MODE_TRIGGER) & (count_q == cmp_q);
	wire trig_w  = match_w & ~match_prev_q;
	wire wr_cnt  = wr_lo | (wr_hi & ~wide);
	wire ovf_w   = inc_w & (count_q == sixteen_bit_timer_pkg::COUNT_MAX) & ~wr_cnt & ~trig_w;

	// next count: writes, then trigger reset, then increment
	always_comb begin
		count_d = count_q;
		if (wr_lo) begin
			count_d[7:0] = pwdata_i[7:0];
			if (wide) count_d[15:8] = buf_q;
		end else if (wr_hi & ~wide) begin
			count_d[15:8] = pwdata_i[7:0];
		end else if (trig_w) begin
			count_d = 16'h0000;
		end else if (inc_w) begin
			count_d = count_q + 16'h0001;
		end
	end

	// counter, prescaler and edge history
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			count_q      <= 16'h0000;
			pre_q        <= 3'h0;
			sel_prev_q   <= 1'b0;
			match_prev_q <= 1'b0;
		end else begin
			count_q      <= count_d;
			pre_q        <= wr_lo ? 3'h0 : (cnt_tick ? pre_q + 3'h1 : pre_q);
			sel_prev_q   <= sel_pin;
			match_prev_q <= match_w;
		end
	end

	// buffer: loaded in wide mode only, by low reads and by high writes
	always_ff @(posedge clk_i) begin
		if (rst_i)                buf_q <= 8'h00;
		else if (wr_hi & wide)    buf_q <= pwdata_i[7:0];
		else if (rd_lo & wide)    buf_q <= count_q[15:8];
	end

	// software registers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_q             <= sixteen_bit_timer_pkg::CTRL_RESET;
			cmp_q              <= 16'h0000;
			cmp_mode_q         <= 4'h0;
			mask_q             <= 1'b0;
			port_c_direction_q <= sixteen_bit_timer_pkg::PORT_DIR_RESET;
		end else begin
			if (wr_ctrl) ctrl_q             <= pwdata_i[7:0] & 8'hBF;
			if (wr_cmp)  cmp_q              <= pwdata_i[15:0];
			if (wr_mode) cmp_mode_q         <= pwdata_i[3:0];
			if (wr_mask) mask_q             <= pwdata_i[sixteen_bit_timer_pkg::STATUS_OVF_BIT];
			if (wr_dir)  port_c_direction_q <= pwdata_i[1:0];
		end
	end

	// sticky overflow flag; a new overflow beats a write-one clear
	wire clr_w = wr_stat & pwdata_i[sixteen_bit_timer_pkg::STATUS_OVF_BIT];
	always_ff @(posedge clk_i) begin
		if (rst_i)      status_q <= 1'b0;
		else if (ovf_w) status_q <= 1'b1;
		else if (clr_w) status_q <= 1'b0;
	end

	// registered outputs
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			prdata_q  <= 32'h00000000;
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
			irq_q     <= 1'b0;
			conv_q    <= 1'b0;
			port_oe_q <= 2'h0;
		end else begin
			pready_q  <= setup_w;
			pslverr_q <= setup_w & ~mapped_w;
			if (setup_w) prdata_q <= pwrite_i ? 32'h00000000 : rd_word;
			irq_q     <= status_q & mask_q;
			conv_q    <= trig_w & adc_enable_i;
			port_oe_q <= ctrl_q.low_power_osc_enable ? 2'h0 : ~port_c_direction_q;
		end
	end

	assign prdata_o           = prdata_q;
	assign pready_o           = pready_q;
	assign pslverr_o          = pslverr_q;
	assign irq_o              = irq_q;
	assign conversion_start_o = conv_q;
	assign port_c_oe_o        = port_oe_q;

	// checks beside the logic
	a_hold_off: assert property (@(posedge clk_i) disable iff (rst_i)
		(!ctrl_q.counter_on && !wr_cnt && !trig_w) |=> $stable(count_q))
		else $error("count moved while counter off");
	a_timer_rate: assert property (@(posedge clk_i) disable iff (rst_i)
		(!ctrl_q.count_clock_source_sel && !instr_tick && !wr_cnt && !trig_w)
		|=> $stable(count_q))
		else $error("timer counted off an instruction cycle");
	a_osc_pins: assert property (@(posedge clk_i) disable iff (rst_i)
		ctrl_q.low_power_osc_enable |=> (port_c_oe_o == 2'h0))
		else $error("oscillator pin driven");
	a_trig_reset: assert property (@(posedge clk_i) disable iff (rst_i)
		(trig_w && !wr_cnt) |=> (count_q == 16'h0000) && (conversion_start_o == $past(adc_enable_i)))
		else $error("trigger reset or conversion wrong");
	a_trig_noflag: assert property (@(posedge clk_i) disable iff (rst_i)
		(trig_w && !status_q) |=> !status_q)
		else $error("trigger set overflow flag");
	a_write_wins: assert property (@(posedge clk_i) disable iff (rst_i)
		(wr_lo && trig_w) |=> (count_q[7:0] == $past(pwdata_i[7:0])))
		else $error("trigger beat a count write");
	a_wrap_flag: assert property (@(posedge clk_i) disable iff (rst_i)
		ovf_w |=> (count_q == 16'h0000) && status_q ##1 (irq_o == $past(mask_q)))
		else $error("wrap did not latch flag");
	a_irq_gate: assert property (@(posedge clk_i) disable iff (rst_i)
		!(status_q && mask_q) |=> !irq_o)
		else $error("interrupt without enabled flag");
	a_buf_copy: assert property (@(posedge clk_i) disable iff (rst_i)
		(rd_lo && wide) |=> (buf_q == $past(count_q[15:8])))
		else $error("low read did not copy high byte");
	a_hi_buffer: assert property (@(posedge clk_i) disable iff (rst_i)
		(wr_hi && wide && !trig_w && !inc_w) |=> $stable(count_q) && (buf_q == $past(pwdata_i[7:0])))
		else $error("wide high write touched live byte");
	a_pre_keep: assert property (@(posedge clk_i) disable iff (rst_i)
		(wr_hi && !cnt_tick) |=> $stable(pre_q))
		else $error("high write changed prescaler");
	a_sleep_timer: assert property (@(posedge clk_i) disable iff (rst_i)
		(sleep_i && !ctrl_q.count_clock_source_sel && !wr_cnt && !trig_w) |=> $stable(count_q))
		else $error("timer mode counted in sleep");
	// timer mode steps by one on an instruction tick at 1:1
	a_timer_step: assert property (@(posedge clk_i) disable iff (rst_i)
		(!ctrl_q.count_clock_source_sel && ctrl_q.counter_on && instr_tick && !sleep_i
		&& (ctrl_q.input_prescale_sel == 2'h0) && !wr_cnt && !trig_w) |=> (count_q == $past(count_q) + 16'h0001))
		else $error("timer missed an instruction tick");
	// asynchronous counter steps on an edge even in sleep
	a_async_count: assert property (@(posedge clk_i) disable iff (rst_i)
		(ctrl_q.count_clock_source_sel && asyn && ctrl_q.counter_on && ext_rise
		&& (ctrl_q.input_prescale_sel == 2'h0) && !wr_cnt && !trig_w) |=> (count_q == $past(count_q) + 16'h0001))
		else $error("asynchronous counter missed an edge");
	// external mode holds without an edge
	a_ext_hold: assert property (@(posedge clk_i) disable iff (rst_i)
		(ctrl_q.count_clock_source_sel && !ext_tick && !wr_cnt && !trig_w)
		|=> $stable(count_q))
		else $error("external mode counted without an edge");
	// ticks that the prescaler swallows leave the count alone
	a_prescale_skip: assert property (@(posedge clk_i) disable iff (rst_i)
		(cnt_tick && ((pre_q & pre_mask) != pre_mask) && !wr_cnt && !trig_w)
		|=> $stable(count_q))
		else $error("prescaler passed a tick early");
	// low byte write clears the prescaler
	a_pre_clear: assert property (@(posedge clk_i) disable iff (rst_i)
		wr_lo
		|=> (pre_q == 3'h0))
		else $error("low write kept prescaler");
	// prescaler moves only on a tick or a low write
	a_pre_hold: assert property (@(posedge clk_i) disable iff (rst_i)
		(!cnt_tick && !wr_lo)
		|=> $stable(pre_q))
		else $error("prescaler moved without a tick");
	// buffer changes only through wide high writes and low reads
	a_buf_hold: assert property (@(posedge clk_i) disable iff (rst_i)
		(!wide || (!wr_hi && !rd_lo))
		|=> $stable(buf_q))
		else $error("buffer changed on its own");
	// wide high read returns the buffer
	a_hi_read: assert property (@(posedge clk_i) disable iff (rst_i)
		(setup_w && !pwrite_i && wide && (paddr_i == sixteen_bit_timer_pkg::ADDR_CNT_HI))
		|=> (prdata_o[7:0] == $past(buf_q)))
		else $error("wide high read bypassed buffer");
	// read data is the word selected at setup
	a_read_data: assert property (@(posedge clk_i) disable iff (rst_i)
		(setup_w && !pwrite_i)
		|=> (prdata_o == $past(rd_word)))
		else $error("read data not captured at setup");
	// writes return zero data
	a_write_zero: assert property (@(posedge clk_i) disable iff (rst_i)
		(setup_w && pwrite_i)
		|=> (prdata_o == 32'h00000000))
		else $error("write returned data");
	// ready follows every setup
	a_ready_after: assert property (@(posedge clk_i) disable iff (rst_i)
		setup_w
		|=> pready_o)
		else $error("no ready after setup");
	// ready never stands without a setup before it
	a_ready_only: assert property (@(posedge clk_i) disable iff (rst_i)
		!setup_w
		|=> !pready_o)
		else $error("ready without setup");
	// unmapped addresses answer with an error
	a_err_unmapped: assert property (@(posedge clk_i) disable iff (rst_i)
		(setup_w && !mapped_w)
		|=> pslverr_o)
		else $error("unmapped address without error");
	// mapped addresses answer cleanly
	a_err_mapped: assert property (@(posedge clk_i) disable iff (rst_i)
		!(setup_w && !mapped_w)
		|=> !pslverr_o)
		else $error("error on a mapped address");
	// compare pair takes the written word
	a_cmp_write: assert property (@(posedge clk_i) disable iff (rst_i)
		wr_cmp
		|=> (cmp_q == $past(pwdata_i[15:0])))
		else $error("compare pair not written");
	// wide low write loads both bytes at once
	a_wide_write: assert property (@(posedge clk_i) disable iff (rst_i)
		(wr_lo && wide)
		|=> (count_q == {$past(buf_q), $past(pwdata_i[7:0])}))
		else $error("wide low write lost a byte");
	// narrow high write reaches the live byte
	a_narrow_high: assert property (@(posedge clk_i) disable iff (rst_i)
		(wr_hi && !wide)
		|=> (count_q[15:8] == $past(pwdata_i[7:0])))
		else $error("narrow high write lost");
	// narrow low write leaves the high byte
	a_lo_write: assert property (@(posedge clk_i) disable iff (rst_i)
		(wr_lo && !wide)
		|=> (count_q == {$past(count_q[15:8]), $past(pwdata_i[7:0])}))
		else $error("narrow low write wrong");
	// write one clears the flag when no overflow competes
	a_flag_clear: assert property (@(posedge clk_i) disable iff (rst_i)
		(clr_w && !ovf_w)
		|=> !status_q)
		else $error("flag not cleared");
	// flag stays until cleared
	a_flag_sticky: assert property (@(posedge clk_i) disable iff (rst_i)
		(status_q && !clr_w)
		|=> status_q)
		else $error("flag dropped by itself");
	// only an overflow sets the flag
	a_flag_source: assert property (@(posedge clk_i) disable iff (rst_i)
		(!status_q && !ovf_w)
		|=> !status_q)
		else $error("flag set without overflow");
	// enabled flag raises the interrupt
	a_irq_level: assert property (@(posedge clk_i) disable iff (rst_i)
		(status_q && mask_q)
		|=> irq_o)
		else $error("enabled flag without interrupt");
	// conversion start only after a trigger
	a_conv_gate: assert property (@(posedge clk_i) disable iff (rst_i)
		!trig_w
		|=> !conversion_start_o)
		else $error("conversion without trigger");
	// conversion start is a single pulse
	a_conv_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
		conversion_start_o
		|=> !conversion_start_o)
		else $error("conversion start too long");
	// pin enables follow the directions while the oscillator is off
	a_oe_follow: assert property (@(posedge clk_i) disable iff (rst_i)
		!ctrl_q.low_power_osc_enable
		|=> (port_c_oe_o == ~$past(port_c_direction_q)))
		else $error("pin enable ignores direction");
	// synchronous counter stops in sleep
	a_sync_sleep: assert property (@(posedge clk_i) disable iff (rst_i)
		(ctrl_q.count_clock_source_sel && !asyn && sleep_i && !wr_cnt && !trig_w)
		|=> $stable(count_q))
		else $error("synchronous counter ran in sleep");
	// instruction ticks are single cycles
	a_tick_gap: assert property (@(posedge clk_i) disable iff (rst_i)
		instr_tick
		|=> !instr_tick)
		else $error("instruction tick too long");
	// unimplemented control bit stays clear
	a_bit6_zero: assert property (@(posedge clk_i) disable iff (rst_i)
		!ctrl_q.unused6)
		else $error("unimplemented control bit set");
endmodule : sixteen_bit_counter

// file: ext_clock_source.sv
// Purpose: model of the external count clock source that drives the pin
// Assumes: pulses are whole, high for four clocks and low for four
// Notes:   the pin stands low outside a burst of pulses
`timescale 1ns/10ps
module ext_clock_source (
	input  wire logic clk_i,
	output logic      pin_o
);
	// idle level until a burst is requested
	initial pin_o = 1'b0;

	// send n rising edges, each held long enough for the two-flop sync
	task fire(input int n);
		for (int i = 0; i < n; i++) begin
			repeat (4) @(posedge clk_i);
			pin_o <= 1'b1;
			repeat (4) @(posedge clk_i);
			pin_o <= 1'b0;
		end
		repeat (4) @(posedge clk_i);
	endtask : fire
endmodule : ext_clock_source

// file: sixteen_bit_timer_counter_tb_top.sv
// Purpose: self-checking bench for the 16-bit timer/counter
// Assumes: the APB answer comes whenever pready_o is high
// Notes:   register rows run in one loop, counting cases by hand after
`timescale 1ns/10ps
module sixteen_bit_timer_counter_tb_top;
	typedef struct packed {
		logic [7:0]  addr;
		logic [31:0] wdata;
		logic [31:0] exp;
	} row_t;
	logic        clk, rst, psel, penable, pwrite, sleep, adc_en, err;
	logic        pready, pslverr, ext_pin, osc_pin, conv, irq;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [1:0]  oe;
	int          fail_count, checks, n;
	row_t        rows [5];
	logic [23:0] ext_rows [7];

	sixteen_bit_counter #(.INSTR_DIV(4)) dut (.clk_i(clk), .rst_i(rst), .psel_i(psel),
		.penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
		.prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
		.ext_count_clock_pin_i(ext_pin), .osc_input_pin_i(osc_pin), .sleep_i(sleep),
		.adc_enable_i(adc_en), .port_c_oe_o(oe), .conversion_start_o(conv), .irq_o(irq));
	ext_clock_source src (.clk_i(clk), .pin_o(ext_pin));
	ext_clock_source osc (.clk_i(clk), .pin_o(osc_pin));

	// free-running clock
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	task finish_test;
		$display("comparisons %0d mismatches %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : finish_test

	task chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	// one APB transfer: setup, then access held until pready
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) begin chk(0, 1); finish_test(); end
		rd = prdata; err = pslverr;
		psel <= 1'b0; penable <= 1'b0;
	endtask : apb

	task rdc(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0000_0000);
		chk(rd, exp);
	endtask : rdc

	// wait for a design output with a bound; which picks irq or conversion
	task wait_out(input logic which);
		n = 0;
		while ((which ? conv : irq) !== 1'b1 && n < 300) begin
			@(posedge clk);
			n++;
		end
		if (n >= 300) begin chk(0, 1); finish_test(); end
	endtask : wait_out

	initial begin
		rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
		pwdata = 32'h0; sleep = 1'b0; adc_en = 1'b1; fail_count = 0; checks = 0;
		rows = '{'{sixteen_bit_timer_pkg::ADDR_PORT_DIR, 32'hFFFF_FFFF, 32'h0000_0003},
			'{sixteen_bit_timer_pkg::ADDR_MASK, 32'h0000_0001, 32'h0000_0001},
			'{sixteen_bit_timer_pkg::ADDR_CMP_VAL, 32'h0000_1234, 32'h0000_1234},
			'{sixteen_bit_timer_pkg::ADDR_CTRL, 32'h0000_007E, 32'h0000_003E},
			'{sixteen_bit_timer_pkg::ADDR_PORT_DIR, 32'h0000_0000, 32'h0000_0000}};
		// control, sleep, pulses, expected count
		ext_rows = '{24'h03_0_5_05, 24'h07_1_5_05, 24'h03_1_5_00,
			24'h13_0_8_04, 24'h23_0_8_02, 24'h33_0_8_01, 24'h0F_1_3_03};
		repeat (16) @(posedge clk);
		chk({conv, pslverr, irq, pready, oe}, 6'h00);
		chk(prdata, 32'h0);
		rst <= 1'b0;
		rdc(sixteen_bit_timer_pkg::ADDR_CTRL, 32'h0);
		rdc(sixteen_bit_timer_pkg::ADDR_STATUS, 32'h0);
		// register rows: write, read back
		foreach (rows[i]) begin
			apb(1'b1, rows[i].addr, rows[i].wdata);
			rdc(rows[i].addr, rows[i].exp);
		end
		apb(1'b1, sixteen_bit_timer_pkg::ADDR_CTRL, 32'h0);
		apb(1'b0, 8'h40, 32'h0);
		chk(err, 1'b1);
		chk(rd, 32'h0);
		$display("register rows done");
		// overflow from FFFE in timer mode
		apb(1'b1, sixteen_bit_timer_pkg::ADDR_CNT_HI, 32'hFF);
		apb(1'b1, sixteen_bit_timer_pkg::ADDR_CNT_LO, 32'hFE);
		apb(1'b1, sixteen_bit_timer_pkg::ADDR_CTRL, 32'h01);
		wait_out(1'b0);
		chk(irq, 1'b1);
		apb(1'b1, sixteen_bit_timer_pkg::ADDR_MASK, 32'h0);
		repeat (3) @(posedge clk);
		chk(irq, 1'b0);
		rdc(sixteen_bit_timer_pkg::ADDR_STATUS, 32'h1);
		apb(1'b1, sixteen_bit_timer_pkg::ADDR_STATUS, 32'h1);
		rdc(sixteen_bit_timer_pkg::ADDR_STATUS, 32'h0);
		$display("overflow done");
		// trigger reset in timer mode acts as a period
		apb(1'b1, sixteen_bit_timer_pkg::ADDR_CTRL, 32'h0);
		apb(1'b1, sixteen_bit_timer_pkg::ADDR_CMP_VAL, 32'h10);
		apb(1'b1, sixteen_bit_timer_pkg::ADDR_CMP_MODE, 32'hB);
		apb(1'b1, sixteen_bit_timer_pkg::ADDR_CNT_HI, 32'h0);
		apb(1'b1, sixteen_bit_timer_pkg::ADDR_CNT_LO, 32'h0);
		apb(1'b1, sixteen_bit_timer_pkg::ADDR_CTRL, 32'h01);
		wait_out(1'b1);
		// converter off: triggers still reset, but start no conversion
		adc_en <= 1'b0;
		n = 0;
		repeat (120) begin
			@(posedge clk);
			if (conv === 1'b1) n++;
		end
		chk(n, 0);
		adc_en <= 1'b1;
		apb(1'b1, sixteen_bit_timer_pkg::ADDR_CTRL, 32'h0);
		apb(1'b0, sixteen_bit_timer_pkg::ADDR_CNT_LO, 32'h0);
		chk(rd < 32'h10, 1'b1);
		rdc(sixteen_bit_timer_pkg::ADDR_STATUS, 32'h0);
		apb(1'b1, sixteen_bit_timer_pkg::ADDR_CMP_MODE, 32'h0);
		$display("trigger done");
		// oscillator enable overrides the pin directions
		chk(oe, 2'h3);
		apb(1'b1, sixteen_bit_timer_pkg::ADDR_CTRL, 32'h08);
		repeat (2) @(posedge clk);
		chk(oe, 2'h0);
		// wide access goes through the high byte buffer
		apb(1'b1, sixteen_bit_timer_pkg::ADDR_CTRL, 32'h80);
		apb(1'b1, sixteen_bit_timer_pkg::ADDR_CNT_HI, 32'hAB);
		apb(1'b1, sixteen_bit_timer_pkg::ADDR_CTRL, 32'h00);
		rdc(sixteen_bit_timer_pkg::ADDR_CNT_HI, 32'h00);
		apb(1'b1, sixteen_bit_timer_pkg::ADDR_CTRL, 32'h80);
		apb(1'b1, sixteen_bit_timer_pkg::ADDR_CNT_LO, 32'hCD);
		apb(1'b1, sixteen_bit_timer_pkg::ADDR_CTRL, 32'h00);
		rdc(sixteen_bit_timer_pkg::ADDR_CNT_HI, 32'hAB);
		apb(1'b1, sixteen_bit_timer_pkg::ADDR_CTRL, 32'h80);
		rdc(sixteen_bit_timer_pkg::ADDR_CNT_LO, 32'hCD);
		rdc(sixteen_bit_timer_pkg::ADDR_CNT_HI, 32'hAB);
		$display("wide access done");
		// timer mode stands still in sleep
		sleep <= 1'b1;
		apb(1'b1, sixteen_bit_timer_pkg::ADDR_CNT_LO, 32'h0);
		apb(1'b1, sixteen_bit_timer_pkg::ADDR_CTRL, 32'h01);
		repeat (40) @(posedge clk);
		apb(1'b1, sixteen_bit_timer_pkg::ADDR_CTRL, 32'h0);
		sleep <= 1'b0;
		rdc(sixteen_bit_timer_pkg::ADDR_CNT_LO, 32'h0);
		$display("sleep timer done");
		// external pulses: sync and async, sleep, every prescale code
		foreach (ext_rows[i]) begin
			apb(1'b1, sixteen_bit_timer_pkg::ADDR_CTRL, 32'h0);
			apb(1'b1, sixteen_bit_timer_pkg::ADDR_CNT_HI, 32'h0);
			apb(1'b1, sixteen_bit_timer_pkg::ADDR_CNT_LO, 32'h0);
			apb(1'b1, sixteen_bit_timer_pkg::ADDR_CTRL, {24'h0, ext_rows[i][23:16]});
			sleep <= ext_rows[i][12];
			if (ext_rows[i][19]) osc.fire(int'(ext_rows[i][11:8]));
			else src.fire(int'(ext_rows[i][11:8]));
			sleep <= 1'b0;
			apb(1'b1, sixteen_bit_timer_pkg::ADDR_CTRL, 32'h0);
			rdc(sixteen_bit_timer_pkg::ADDR_CNT_LO, {24'h0, ext_rows[i][7:0]});
		end
		$display("external count done");
		// reset in mid-run clears count and control
		apb(1'b1, sixteen_bit_timer_pkg::ADDR_CNT_LO, 32'h55);
		apb(1'b1, sixteen_bit_timer_pkg::ADDR_CTRL, 32'h01);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		chk({conv, pslverr, irq, pready, oe}, 6'h00);
		rst <= 1'b0;
		rdc(sixteen_bit_timer_pkg::ADDR_CTRL, 32'h0);
		rdc(sixteen_bit_timer_pkg::ADDR_CNT_LO, 32'h0);
		$display("mid-run reset done");
		finish_test();
	end
endmodule : sixteen_bit_timer_counter_tb_top
